// >>> design/isgc_pkg.sv
package isgc_pkg;

  // Command opcodes and feature option values.
  localparam logic [7:0] CMD_IDLE       = 8'he3;
  localparam logic [7:0] CMD_IDLE_ALT   = 8'h97;
  localparam logic [7:0] CMD_IDLE_IMM   = 8'he1;
  localparam logic [7:0] CMD_IDLE_IMM2  = 8'h95;
  localparam logic [7:0] CMD_INIT_GEOM  = 8'h91;
  localparam logic [7:0] FEAT_KEEP      = 8'h66;
  localparam logic [7:0] FEAT_REVERT    = 8'hcc;

  // Timeout encodings.
  localparam logic [7:0] TMO_MUL5_MAX   = 8'hf0;
  localparam logic [7:0] TMO_MUL30_MAX  = 8'hfb;
  localparam logic [7:0] TMO_21MIN      = 8'hfc;
  localparam logic [7:0] TMO_8H         = 8'hfd;
  localparam logic [7:0] TMO_ABORT      = 8'hfe;
  localparam logic [7:0] TMO_BASE30     = 8'hf0;

  // Interval units in seconds.
  localparam int unsigned SEC_UNIT5     = 5;
  localparam int unsigned SEC_UNIT30M   = 1800;
  localparam int unsigned SEC_21MIN     = 1260;
  localparam int unsigned SEC_8H        = 28800;
  localparam int unsigned SEC_21M15S    = 1275;

  // Clock: 40 MHz, one-second tick.
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned TICK_SEC      = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ * TICK_SEC;

  // APB register byte offsets.
  localparam logic [7:0] OFS_CMD        = 8'h00;
  localparam logic [7:0] OFS_ERROR      = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_GEOM       = 8'h0c;
  localparam logic [7:0] OFS_TIMER      = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
  localparam logic [7:0] OFS_CTRL       = 8'h1c;

  // Field positions and the interrupt field width.
  localparam int ERR_ABT                = 2;
  localparam int ST_ERR                 = 0;
  localparam int ST_DSC                 = 4;
  localparam int ST_DF                  = 5;
  localparam int ST_RDY                 = 6;
  localparam int ST_BSY                 = 7;
  localparam int IRQ_DONE               = 0;
  localparam int IRQ_ABORT              = 1;
  localparam int IRQ_STANDBY            = 2;
  localparam int IRQ_W                  = 3;

  // Reset values.
  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] ERROR_RST      = 8'h00;

  typedef enum logic [1:0] {
    ISGC_STANDBY = 2'b01,
    ISGC_IDLE    = 2'b10
  } isgc_pmode_t;

endpackage : isgc_pkg

// >>> design/isgc_timeout_decode.sv
`timescale 1ns/1ps
`default_nettype none
module isgc_timeout_decode (
  // Encoded timeout.
  input  wire logic [7:0]  code,
  // Decoded interval.
  output var  logic [15:0] seconds,
  output var  logic        enable,
  output var  logic        abort
);
  always_comb begin
    seconds = 16'h0000;
    enable  = 1'b1;
    abort   = 1'b0;
    if (code == 8'h00) begin
      enable = 1'b0;
    end else if (code <= isgc_pkg::TMO_MUL5_MAX) begin
      seconds = 16'(code * isgc_pkg::SEC_UNIT5);
    end else if (code <= isgc_pkg::TMO_MUL30_MAX) begin
      seconds = 16'((code - isgc_pkg::TMO_BASE30) * isgc_pkg::SEC_UNIT30M);
    end else if (code == isgc_pkg::TMO_21MIN) begin
      seconds = 16'(isgc_pkg::SEC_21MIN);
    end else if (code == isgc_pkg::TMO_8H) begin
      seconds = 16'(isgc_pkg::SEC_8H);
    end else if (code == isgc_pkg::TMO_ABORT) begin
      enable = 1'b0;
      abort  = 1'b1;
    end else begin
      seconds = 16'(isgc_pkg::SEC_21M15S);
    end
  end
endmodule : isgc_timeout_decode
`default_nettype wire

// >>> design/isgc_core.sv
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module isgc_core #(
  parameter int unsigned TICK_CYCLES = isgc_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Drive-side events.
  input  wire logic        host_access,
  input  wire logic        soft_reset,
  input  wire logic        spindle_at_speed,
  // Spindle, identify and interrupt outputs.
  output var  logic        spin_up_req,
  output var  logic        standby,
  output var  logic [7:0]  ident_sectors,
  output var  logic [3:0]  ident_heads_m1,
  output var  logic        irq
);

  typedef struct packed {
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    isgc_pkg::isgc_pmode_t mode;
    logic [7:0]            tmo_code;
    logic                  apd_en;
    logic [15:0]           sec_left;
    logic [15:0]           sec_full;
    logic [31:0]           tick;
    logic [7:0]            err;
    logic [7:0]            stat;
    logic [7:0]            sectors;
    logic [3:0]            heads;
    logic [7:0]            feat_opt;
    logic                  spin_up;
    logic [isgc_pkg::IRQ_W-1:0] irq_stat;
    logic [isgc_pkg::IRQ_W-1:0] irq_mask;
    logic                  irq;
    logic [2:0]            hsync;
  } isgc_state_t;

  isgc_state_t st;
  isgc_state_t next_st;

  logic [15:0] dec_seconds;
  logic        dec_enable;
  logic        dec_abort;

  isgc_timeout_decode u_dec (
    .code    (pwdata[15:8]),
    .seconds (dec_seconds),
    .enable  (dec_enable),
    .abort   (dec_abort)
  );

  logic                       wr_acc;
  logic                       rd_acc;
  logic [7:0]                 opcode;
  logic [isgc_pkg::IRQ_W-1:0] ev;
  logic                       access_evt;

  always_comb begin
    next_st    = st;
    ev         = '0;
    wr_acc     = psel && penable && pwrite;
    rd_acc     = psel && !penable && !pwrite;
    opcode     = pwdata[7:0];
    next_st.hsync = {st.hsync[1:0], host_access};
    access_evt = st.hsync[1] && !st.hsync[2];
    next_st.pready  = psel && !penable;
    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0000_0000;

    next_st.spin_up = (st.mode == isgc_pkg::ISGC_IDLE) && !spindle_at_speed;
    next_st.stat[isgc_pkg::ST_RDY] = (st.mode == isgc_pkg::ISGC_IDLE) && spindle_at_speed;
    next_st.stat[isgc_pkg::ST_DSC] = spindle_at_speed;

    if (st.apd_en && st.mode == isgc_pkg::ISGC_IDLE) begin
      if (access_evt) begin
        next_st.sec_left = st.sec_full;
        next_st.tick     = 32'h0000_0000;
      end else if (st.tick == 32'(TICK_CYCLES - 1)) begin
        next_st.tick = 32'h0000_0000;
        if (st.sec_left <= 16'h0001) begin
          next_st.mode = isgc_pkg::ISGC_STANDBY;
          ev[isgc_pkg::IRQ_STANDBY] = 1'b1;
        end else begin
          next_st.sec_left = st.sec_left - 16'h0001;
        end
      end else begin
        next_st.tick = st.tick + 32'h0000_0001;
      end
    end

    if (soft_reset && st.feat_opt == isgc_pkg::FEAT_REVERT) begin
      next_st.sectors = 8'h00;
      next_st.heads   = 4'h0;
    end

    if (st.pready && psel && penable) begin
      next_st.pready = 1'b0;
    end

    // Write effects land at the edge that ends the access phase, where the master samples pready.
    if (wr_acc && st.pready) begin
      if (paddr == isgc_pkg::OFS_CMD) begin
        next_st.stat[isgc_pkg::ST_BSY] = 1'b0;
        next_st.stat[isgc_pkg::ST_DF]  = 1'b0;
        next_st.err = 8'h00;
        next_st.stat[isgc_pkg::ST_ERR] = 1'b0;
        if (opcode == isgc_pkg::CMD_IDLE || opcode == isgc_pkg::CMD_IDLE_ALT) begin
          if (dec_abort) begin
            next_st.err[isgc_pkg::ERR_ABT] = 1'b1;
            next_st.stat[isgc_pkg::ST_ERR] = 1'b1;
            ev[isgc_pkg::IRQ_ABORT] = 1'b1;
          end else begin
            next_st.mode     = isgc_pkg::ISGC_IDLE;
            next_st.tmo_code = pwdata[15:8];
            next_st.apd_en   = dec_enable;
            next_st.sec_full = dec_seconds;
            next_st.sec_left = dec_seconds;
            next_st.tick     = 32'h0000_0000;
            ev[isgc_pkg::IRQ_DONE] = 1'b1;
          end
        end else if (opcode == isgc_pkg::CMD_IDLE_IMM || opcode == isgc_pkg::CMD_IDLE_IMM2) begin
          next_st.mode = isgc_pkg::ISGC_IDLE;
          next_st.sec_left = st.sec_full;
          ev[isgc_pkg::IRQ_DONE] = 1'b1;
        end else if (opcode == isgc_pkg::CMD_INIT_GEOM) begin
          next_st.sectors = pwdata[15:8];
          next_st.heads   = pwdata[19:16];
          ev[isgc_pkg::IRQ_DONE] = 1'b1;
        end else begin
          next_st.err[isgc_pkg::ERR_ABT] = 1'b1;
          next_st.stat[isgc_pkg::ST_ERR] = 1'b1;
          ev[isgc_pkg::IRQ_ABORT] = 1'b1;
        end
      end else if (paddr == isgc_pkg::OFS_IRQ_STAT) begin
        next_st.irq_stat = st.irq_stat & ~pwdata[isgc_pkg::IRQ_W-1:0];
      end else if (paddr == isgc_pkg::OFS_IRQ_MASK) begin
        next_st.irq_mask = pwdata[isgc_pkg::IRQ_W-1:0];
      end else if (paddr == isgc_pkg::OFS_CTRL) begin
        next_st.feat_opt = pwdata[7:0];
      end
    end

    // Unmapped writes are refused in setup so the error stands together with pready.
    if (psel && !penable && pwrite &&
        paddr != isgc_pkg::OFS_CMD && paddr != isgc_pkg::OFS_ERROR && paddr != isgc_pkg::OFS_STATUS &&
        paddr != isgc_pkg::OFS_GEOM && paddr != isgc_pkg::OFS_TIMER && paddr != isgc_pkg::OFS_IRQ_STAT &&
        paddr != isgc_pkg::OFS_IRQ_MASK && paddr != isgc_pkg::OFS_CTRL) begin
      next_st.pslverr = 1'b1;
    end

    // Read data is latched at the setup edge so it stands during the access phase.
    if (rd_acc) begin
      if (paddr == isgc_pkg::OFS_CMD) begin
        next_st.prdata = 32'h0000_0000;
      end else if (paddr == isgc_pkg::OFS_ERROR) begin
        next_st.prdata = {24'h000000, st.err};
      end else if (paddr == isgc_pkg::OFS_STATUS) begin
        next_st.prdata = {24'h000000, st.stat};
      end else if (paddr == isgc_pkg::OFS_GEOM) begin
        next_st.prdata = {20'h00000, st.heads, st.sectors};
      end else if (paddr == isgc_pkg::OFS_TIMER) begin
        next_st.prdata = {st.sec_left, 6'h00, st.mode, st.tmo_code};
      end else if (paddr == isgc_pkg::OFS_IRQ_STAT) begin
        next_st.prdata = {29'h00000000, st.irq_stat};
      end else if (paddr == isgc_pkg::OFS_IRQ_MASK) begin
        next_st.prdata = {29'h00000000, st.irq_mask};
      end else if (paddr == isgc_pkg::OFS_CTRL) begin
        next_st.prdata = {24'h000000, st.feat_opt};
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    // Set wins over a same-cycle clear.
    next_st.irq_stat = next_st.irq_stat | ev;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.mode     <= isgc_pkg::ISGC_STANDBY;
      st.stat     <= isgc_pkg::STATUS_RST;
      st.err      <= isgc_pkg::ERROR_RST;
      st.feat_opt <= isgc_pkg::FEAT_KEEP;
    end else begin
      st <= next_st;
    end
  end

  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign spin_up_req    = st.spin_up;
  assign standby        = (st.mode == isgc_pkg::ISGC_STANDBY);
  assign ident_sectors  = st.sectors;
  assign ident_heads_m1 = st.heads;
  assign irq            = st.irq;

endmodule : isgc_core
`default_nettype wire

// >>> verification/isgc_host.sv
`timescale 1ns/1ps
`default_nettype none
module isgc_host (
  // Bus clock.
  input  wire logic        pclk,
  // APB master.
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : isgc_host
`default_nettype wire

// >>> verification/isgc_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module isgc_core_assertions (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Bus.
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // Drive side.
  input wire logic       host_access,
  input wire logic       soft_reset,
  input wire logic       spindle_at_speed,
  input wire logic       spin_up_req,
  input wire logic       standby,
  input wire logic [7:0] ident_sectors,
  input wire logic [3:0] ident_heads_m1
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cmd_wr;
  assign cmd_wr = psel && penable && pwrite && (paddr == isgc_pkg::OFS_CMD);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held");
  a_unmapped_error: assert property (psel && !penable && paddr > 8'h1c |=> pslverr)
    else $error("unmapped without error");
  a_spin_when_idle: assert property (!standby && !spindle_at_speed |=> spin_up_req)
    else $error("no spin up in idle");
  a_spin_skip_fast: assert property (standby || spindle_at_speed |=> !spin_up_req)
    else $error("spin up while spinning");
  a_geom_hold: assert property ((!cmd_wr && !soft_reset) [*3] |=> $stable({ident_heads_m1, ident_sectors}))
    else $error("geometry changed");
  a_access_restart: assert property ($rose(host_access) |-> ##4 (!$rose(standby)) [*8])
    else $error("standby right after access");
  a_wake_by_cmd: assert property ($fell(standby) |-> $past(cmd_wr) || $past(cmd_wr, 2))
    else $error("wake without command");
endmodule : isgc_core_assertions
bind isgc_core isgc_core_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .host_access, .soft_reset, .spindle_at_speed, .spin_up_req, .standby, .ident_sectors, .ident_heads_m1);
`default_nettype wire

// >>> verification/tb_idle_standby_geometry_cmds.sv
`timescale 1ns/1ps
`default_nettype none
module tb_idle_standby_geometry_cmds;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        host_access, soft_reset, spindle_at_speed, spin_up_req, standby, irq;
  logic [7:0]  paddr, ident_sectors, c;
  logic [3:0]  ident_heads_m1, h;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] q;
  logic [2:0]  ramp;
  int          fails, num_checks, seed, i;
  logic [7:0]  codes [9] = '{8'h00, 8'h01, 8'hf0, 8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hff, 8'h00};
  isgc_core #(.TICK_CYCLES(4)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .host_access, .soft_reset, .spindle_at_speed, .spin_up_req, .standby,
    .ident_sectors, .ident_heads_m1, .irq);
  isgc_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // The spindle reaches speed a few cycles after leaving standby.
  always @(posedge pclk) begin
    ramp             <= standby ? 3'h0 : {ramp[1:0], 1'b1};
    spindle_at_speed <= ramp[2];
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask : tk
  function automatic logic [15:0] exp_sec(input logic [7:0] v);
    if (v <= isgc_pkg::TMO_MUL5_MAX) return 16'(v * isgc_pkg::SEC_UNIT5);
    if (v <= isgc_pkg::TMO_MUL30_MAX) return 16'((v - isgc_pkg::TMO_BASE30) * isgc_pkg::SEC_UNIT30M);
    if (v == isgc_pkg::TMO_21MIN) return 16'(isgc_pkg::SEC_21MIN);
    if (v == isgc_pkg::TMO_8H) return 16'(isgc_pkg::SEC_8H);
    return 16'(isgc_pkg::SEC_21M15S);
  endfunction : exp_sec
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    fails++;
    finish_test;
  end
  initial begin
    {presetn, host_access, soft_reset} = '0;
    seed = 94;
    tk(4);
    presetn <= 1'b1;
    rd(8'h40);
    chk("slverr", e, 1'b1);
    wr(isgc_pkg::OFS_IRQ_MASK, 32'h2);
    codes[8] = 8'h01 + 8'($unsigned($random(seed)) % 240);
    for (i = 0; i < 9; i++) begin
      wr(isgc_pkg::OFS_CMD, {16'h0, codes[i], i[0] ? isgc_pkg::CMD_IDLE_ALT : isgc_pkg::CMD_IDLE});
      rd(isgc_pkg::OFS_TIMER);
      q = exp_sec(codes[i]);
      chk("secs", (r[31:16] + 16'h1 == q) ? q : r[31:16], q);
      chk("mode", r[9:8], isgc_pkg::ISGC_IDLE);
    end
    for (i = 0; i < 2; i++) begin
      wr(isgc_pkg::OFS_CMD, i ? 32'h0 : {16'h0, isgc_pkg::TMO_ABORT, isgc_pkg::CMD_IDLE});
      rd(isgc_pkg::OFS_ERROR);
      chk("abt", r[isgc_pkg::ERR_ABT], 1'b1);
      rd(isgc_pkg::OFS_STATUS);
      chk("st", {r[isgc_pkg::ST_BSY], r[isgc_pkg::ST_DF], r[isgc_pkg::ST_ERR], irq}, 4'h3);
      wr(isgc_pkg::OFS_IRQ_MASK, 32'h0);
      tk(2);
      chk("mask", irq, 1'b0);
      wr(isgc_pkg::OFS_IRQ_STAT, 32'h7);
      wr(isgc_pkg::OFS_IRQ_MASK, 32'h2);
      tk(2);
      chk("clr", irq, 1'b0);
    end
    wr(isgc_pkg::OFS_CMD, {16'h0, 8'h01, isgc_pkg::CMD_IDLE});
    repeat (6) begin
      tk(10);
      host_access <= 1'b1;
      tk(3);
      host_access <= 1'b0;
    end
    #1 chk("awake", standby, 1'b0);
    for (i = 0; i < 2; i++) begin
      tk(40);
      #1 chk("sleep", standby, 1'b1);
      wr(isgc_pkg::OFS_CMD, {24'h0, i ? isgc_pkg::CMD_IDLE_IMM2 : isgc_pkg::CMD_IDLE_IMM});
      tk(1);
      #1 chk("wake", {standby, spin_up_req}, 2'b01);
      rd(isgc_pkg::OFS_TIMER);
      chk("keep", r[7:0], 8'h01);
      tk(8);
      #1 chk("spun", spin_up_req, 1'b0);
    end
    for (i = 0; i < 4; i++) begin
      c = i ? 8'($random(seed)) : 8'h00;
      h = 4'($random(seed));
      wr(isgc_pkg::OFS_CMD, {12'h0, h, c, isgc_pkg::CMD_INIT_GEOM});
      rd(isgc_pkg::OFS_GEOM);
      chk("geom", {ident_heads_m1, ident_sectors, r[11:0]}, {h, c, h, c});
    end
    for (i = 0; i < 2; i++) begin
      wr(isgc_pkg::OFS_CTRL, i ? 32'(isgc_pkg::FEAT_REVERT) : 32'(isgc_pkg::FEAT_KEEP));
      soft_reset <= 1'b1;
      tk(2);
      soft_reset <= 1'b0;
      tk(2);
      #1 chk("hold", {ident_heads_m1, ident_sectors}, i ? 12'h0 : {h, c});
    end
    finish_test;
  end
endmodule : tb_idle_standby_geometry_cmds
`default_nettype wire
